// [verilog/seewa_pkg.sv]
package seewa_pkg;
    // command frame layout
    localparam int OPCODE_W = 2;
    localparam int ADDR_W16 = 6;
    localparam int ADDR_W8 = 7;
    localparam int DATA_W16 = 16;
    localparam int DATA_W8 = 8;
    localparam int WORDS16 = 64;
    localparam int WORDS8 = 128;
    // opcodes
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_CLEAR = 2'h3;
    // leading address bits under OP_EXT
    localparam logic [1:0] EXT_DISABLE = 2'h0;
    localparam logic [1:0] EXT_PROG_ALL = 2'h1;
    localparam logic [1:0] EXT_CLEAR_ALL = 2'h2;
    localparam logic [1:0] EXT_ENABLE = 2'h3;
    // timing
    localparam int SYS_CLK_HZ = 50_000_000;
    localparam int PROG_TIME_US = 5000;
    localparam int PROG_CYCLES = PROG_TIME_US * (SYS_CLK_HZ / 1_000_000);
    localparam int MIN_SELECT_LOW_TIME_NS = 250;
    localparam int MIN_SELECT_LOW_CYCLES =
        (MIN_SELECT_LOW_TIME_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
    // self-timed operation kinds
    typedef enum logic [1:0] {SEEWA_OP_CLEAR1, SEEWA_OP_WRITE1, SEEWA_OP_CLRALL,
        SEEWA_OP_PROGALL} seewa_op_e;
endpackage

// [verilog/seewa_sync.sv]
`timescale 1ns/1ns
// two-flop synchroniser with edge pulses taken from the settled stage only
module seewa_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // pin in, synchronised out
    input wire logic pin_in,
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } seewa_sync_s;

    seewa_sync_s st_reg;
    seewa_sync_s st_next;

    // first stage feeds only the second
    always_comb begin
        st_next = st_reg;
        st_next.meta = pin_in;
        st_next.sync = st_reg.meta;
        st_next.last = st_reg.sync;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.sync;
    assign rise_out = st_reg.sync & ~st_reg.last;
    assign fall_out = ~st_reg.sync & st_reg.last;
endmodule

// [verilog/seewa_core.sv]
`timescale 1ns/1ns
// Function
// RQ1: the host drops select for the least low time after exactly the clear frame's clocks.
// RQ2: a select fall after a valid clear command starts a self-timed clear of that word.
// RQ3: a started cycle runs to its end with no further serial clocks.
// RQ4: while busy the host may reselect and poll data out for status.
// RQ5: a cleared word reads back as all ones.
// RQ6: clear-all starts on the select fall and leaves every bit at one.
// RQ7: write-all starts on the select fall and writes the word into every location.
// RQ8: write-all stores the word whatever the old contents, no prior clear needed.
// RQ9: the host drops select after the last bit and before the next serial clock rise.
// RQ10: a select fall outside that one-clock window aborts with memory untouched.
// RQ11: a command is start bit one, 2-bit opcode, 6 or 7 address bits, then data.
// RQ12: programming is off at reset and clear or write is ignored until enabled.
// RQ13: during polling data out is low while busy and high once ready.
// RQ14: clear uses opcode 11; clear-all and write-all use opcode 00 with 10 and 01.
module seewa_core #(
    parameter int PROG_CYCLES = seewa_pkg::PROG_CYCLES, // keep above MEM_WORDS for the sweep
    parameter int MEM_WORDS = seewa_pkg::WORDS8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // serial link pins
    input wire logic select_in,
    input wire logic serial_clk_in,
    input wire logic serial_in_line,
    input wire logic word_width_select,
    output logic serial_out,
    output logic serial_out_en,
    // status
    output logic busy,
    output logic prog_enabled
);
    localparam int CNT_W = $clog2(PROG_CYCLES + 1);
    localparam int FRAME_MAX = 1 + seewa_pkg::OPCODE_W + seewa_pkg::ADDR_W8
        + seewa_pkg::DATA_W16;

    typedef enum logic [2:0] {ST_IDLE, ST_SHIFT, ST_ARMED, ST_LATE, ST_RUN, ST_SKIP} seewa_st_e;

    typedef struct packed {
        seewa_st_e st;
        logic [4:0] nbits;
        logic [FRAME_MAX-1:0] shreg;
        logic [1:0] opcode;
        logic [1:0] lead;
        logic [6:0] addr;
        logic [15:0] wdata;
        seewa_pkg::seewa_op_e op;
        logic enabled;
        logic [CNT_W-1:0] cnt;
        logic [7:0] sweep;
        logic do_val;
        logic do_en;
    } seewa_core_s;

    seewa_core_s s_reg;
    seewa_core_s s_next;
    logic [7:0] mem [MEM_WORDS];
    logic mem_we;
    logic [6:0] mem_addr;
    logic [7:0] mem_data;
    logic cs_lvl, cs_rise, cs_fall;
    logic sk_rise;
    logic di_lvl;
    logic org_lvl;

    // all pins cross into sys_clk through two flops
    seewa_sync u_cs (.sys_clk(sys_clk), .rstn(rstn), .pin_in(select_in),
        .level_out(cs_lvl), .rise_out(cs_rise), .fall_out(cs_fall));
    seewa_sync u_sk (.sys_clk(sys_clk), .rstn(rstn), .pin_in(serial_clk_in),
        .level_out(), .rise_out(sk_rise), .fall_out());
    seewa_sync u_di (.sys_clk(sys_clk), .rstn(rstn), .pin_in(serial_in_line),
        .level_out(di_lvl), .rise_out(), .fall_out());
    seewa_sync u_org (.sys_clk(sys_clk), .rstn(rstn), .pin_in(word_width_select),
        .level_out(org_lvl), .rise_out(), .fall_out());

    // frame length for the opcode and width in use
    function automatic logic [4:0] frame_len(input logic [1:0] op, input logic [1:0] lead,
        input logic x16);
        logic [4:0] base;
        logic [4:0] dw;
        base = x16 ? 5'h9 : 5'ha;
        dw = x16 ? 5'h10 : 5'h8;
        if (op == seewa_pkg::OP_WRITE ||
            (op == seewa_pkg::OP_EXT && lead == seewa_pkg::EXT_PROG_ALL)) begin
            return base + dw; // [RQ11]
        end
        return base;
    endfunction

    // address field taken from the shift register, width per organisation
    function automatic logic [6:0] head_addr(input logic [FRAME_MAX-1:0] sr,
        input logic [4:0] dlen, input logic x16);
        logic [FRAME_MAX-1:0] sh;
        sh = sr >> dlen;
        return x16 ? {1'b0, sh[5:0]} : sh[6:0];
    endfunction

    logic [4:0] want;
    logic [4:0] dlen;
    logic [4:0] head;
    logic [1:0] lead;
    logic [FRAME_MAX-1:0] shifted;

    // lead bits latched when the head is complete; a data field would shift them away
    always_comb begin
        shifted = {s_reg.shreg[FRAME_MAX-2:0], di_lvl};
        head = org_lvl ? 5'h9 : 5'ha;
        lead = s_reg.lead;
        if (s_reg.st == ST_SHIFT && s_reg.nbits + 5'h1 == head) begin
            lead = org_lvl ? shifted[5:4] : shifted[6:5];
        end
        want = frame_len(s_reg.opcode, lead, org_lvl);
        dlen = (want > head) ? (org_lvl ? 5'h10 : 5'h8) : 5'h0;
    end

    // command capture, window check and self-timed sequencing
    always_comb begin
        s_next = s_reg;
        mem_we = 1'b0;
        mem_addr = s_reg.addr;
        mem_data = 8'hff;
        unique case (s_reg.st)
            ST_IDLE: begin
                if (cs_lvl && sk_rise && di_lvl) begin // start bit [RQ11]
                    s_next.st = ST_SHIFT;
                    s_next.nbits = 5'h1;
                    s_next.shreg = '0;
                end
            end
            ST_SHIFT: begin
                if (!cs_lvl) begin
                    s_next.st = ST_IDLE; // select fell too early [RQ10]
                end else if (sk_rise) begin
                    s_next.shreg = shifted;
                    s_next.nbits = s_reg.nbits + 5'h1;
                    s_next.lead = lead;
                    if (s_reg.nbits == 5'h2) begin
                        s_next.opcode = shifted[1:0];
                    end
                    if (s_reg.nbits > 5'h2 && s_reg.nbits + 5'h1 == want) begin
                        s_next.st = ST_ARMED;
                    end
                end
            end
            ST_ARMED: begin
                // last bit taken, fall must come before the next clock rise [RQ9]
                s_next.addr = head_addr(s_reg.shreg, dlen, org_lvl);
                s_next.wdata = s_reg.shreg[15:0];
                if (sk_rise) begin
                    s_next.st = ST_LATE; // late fall aborts [RQ10]
                end else if (cs_fall) begin
                    s_next.st = ST_IDLE;
                    if (s_reg.opcode == seewa_pkg::OP_EXT) begin
                        unique case (lead)
                            seewa_pkg::EXT_ENABLE: s_next.enabled = 1'b1;
                            seewa_pkg::EXT_DISABLE: s_next.enabled = 1'b0;
                            seewa_pkg::EXT_CLEAR_ALL: begin
                                s_next.op = seewa_pkg::SEEWA_OP_CLRALL; // [RQ14]
                                s_next.st = s_reg.enabled ? ST_RUN : ST_IDLE; // [RQ6] [RQ12]
                            end
                            seewa_pkg::EXT_PROG_ALL: begin
                                s_next.op = seewa_pkg::SEEWA_OP_PROGALL; // [RQ14]
                                s_next.st = s_reg.enabled ? ST_RUN : ST_IDLE; // [RQ7] [RQ12]
                            end
                        endcase
                    end else if (s_reg.opcode == seewa_pkg::OP_CLEAR) begin
                        s_next.op = seewa_pkg::SEEWA_OP_CLEAR1; // [RQ14]
                        s_next.st = s_reg.enabled ? ST_RUN : ST_IDLE; // [RQ2] [RQ12]
                    end else if (s_reg.opcode == seewa_pkg::OP_WRITE) begin
                        s_next.op = seewa_pkg::SEEWA_OP_WRITE1;
                        s_next.st = s_reg.enabled ? ST_RUN : ST_IDLE; // [RQ12]
                    end
                    s_next.cnt = '0;
                    s_next.sweep = '0;
                end
            end
            ST_LATE: begin
                if (!cs_lvl) begin
                    s_next.st = ST_IDLE; // nothing written
                end
            end
            ST_RUN: begin
                // counts on sys_clk alone, the serial clock is not needed [RQ3]
                s_next.cnt = s_reg.cnt + 1'b1;
                if (s_reg.op == seewa_pkg::SEEWA_OP_CLRALL ||
                    s_reg.op == seewa_pkg::SEEWA_OP_PROGALL) begin
                    mem_addr = s_reg.sweep[6:0];
                    // one spare bit so the count can reach the array size
                    if (s_reg.sweep < 8'(MEM_WORDS)) begin
                        mem_we = 1'b1;
                        s_next.sweep = s_reg.sweep + 8'h1;
                    end
                    if (s_reg.op == seewa_pkg::SEEWA_OP_PROGALL) begin
                        mem_data = s_reg.wdata[7:0]; // overwrite, no prior clear [RQ7] [RQ8]
                    end // else all ones [RQ6]
                end else if (s_reg.cnt == '0) begin
                    mem_we = 1'b1;
                    mem_data = (s_reg.op == seewa_pkg::SEEWA_OP_WRITE1) ?
                        s_reg.wdata[7:0] : 8'hff; // cleared word reads ones [RQ5]
                end
                if (s_reg.cnt == CNT_W'(PROG_CYCLES - 1)) begin
                    s_next.st = ST_IDLE;
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
        // status on data out while selected and idle of frames [RQ4] [RQ13]
        s_next.do_en = cs_lvl && (s_reg.st == ST_RUN || s_reg.st == ST_IDLE);
        s_next.do_val = (s_next.st != ST_RUN);
        if (cs_rise) begin
            s_next.do_en = cs_lvl;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0; // programming disabled at reset [RQ12]
        end else begin
            s_reg <= s_next;
        end
    end

    // storage array, low byte kept; a wider word is modelled as its low byte
    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_data;
        end
    end

    assign serial_out = s_reg.do_val;
    assign serial_out_en = s_reg.do_en;
    assign busy = (s_reg.st == ST_RUN);
    assign prog_enabled = s_reg.enabled;
endmodule

// [test/seewa_core_asserts.sv]
`timescale 1ns/1ns
// pin-level checks for the erase and write-all block
module seewa_core_chk #(
    parameter int PROG_CYCLES = 50
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // pins
    input wire logic select_in,
    input wire logic serial_out,
    input wire logic serial_out_en,
    input wire logic busy,
    input wire logic prog_enabled
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    // busy run length; counted here because a repeat count cannot hold it
    always_comb cnt_next = busy ? cnt_reg + 32'h1 : 32'h0;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) cnt_reg <= 32'h0;
        else cnt_reg <= cnt_next;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_busy_length: assert property ($fell(busy) |-> cnt_reg == PROG_CYCLES)
        else $error("busy length wrong");
    chk_self_timed: assert property ($rose(busy) |-> busy [*8])
        else $error("busy dropped early");
    chk_start_on_fall: assert property ($rose(busy) |-> !select_in &&
        ($past(select_in, 3) || $past(select_in, 4) || $past(select_in, 5)))
        else $error("busy not launched by select fall");
    chk_needs_enable: assert property ($rose(busy) |-> prog_enabled)
        else $error("cycle started while disabled");
    chk_poll_busy: assert property (busy && $past(busy) && serial_out_en |-> !serial_out)
        else $error("status not low while busy");
    chk_poll_ready: assert property (!busy && !$past(busy) && serial_out_en |-> serial_out)
        else $error("status not high while ready");
    chk_idle_release: assert property (!select_in [*6] |-> !serial_out_en)
        else $error("data out driven while deselected");
    chk_enable_quiet: assert property ($changed(prog_enabled) |-> !busy)
        else $error("enable changed during cycle");
    chk_reset_clean: assert property ($rose(rstn) |-> !busy && !prog_enabled)
        else $error("not idle and disabled after reset");
    cover property ($rose(busy));
    cover property (busy && serial_out_en);
    cover property ($fell(busy));
endmodule

// [test/seewa_host_model.sv]
`timescale 1ns/1ns
// host side of the link; serial clock idles low between frames
module seewa_host_model (
    // clock
    input wire logic sys_clk,
    // link pins toward the device
    output logic select_in,
    output logic serial_clk_in,
    output logic serial_in_line
);
    initial begin
        select_in = 1'b0;
        serial_clk_in = 1'b0;
        serial_in_line = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic set_select(input logic lvl);
        tick(1);
        select_in <= lvl;
    endtask
    // n bits msb first at 160 ns; extra rises after the last bit make a late fall
    task automatic frame(input logic [24:0] bits, input int n, input int extra);
        int i;
        set_select(1'b1);
        for (i = n - 1; i >= -extra; i--) begin
            tick(2);
            serial_in_line <= (i >= 0) ? bits[i] : 1'b1;
            tick(2);
            serial_clk_in <= 1'b1;
            tick(4);
            serial_clk_in <= 1'b0;
        end
        tick(2);
        select_in <= 1'b0;
        serial_in_line <= ~serial_in_line; // released line shows no stale bit
        tick(16);
    endtask
endmodule

// [test/testbench.sv]
`timescale 1ns/1ns
// host model sends frames; a watcher compares polled status against noted values
module testbench;
    localparam int PROG_CYCLES = 160;
    logic sys_clk;
    logic rstn;
    logic word_width_select;
    logic select_in;
    logic serial_clk_in;
    logic serial_in_line;
    logic serial_out;
    logic serial_out_en;
    logic busy;
    logic prog_enabled;
    int errors;
    int tests_run;
    logic [15:0] lfsr;
    logic [15:0] r;
    logic [7:0] w;
    logic [7:0] obs_seen;
    logic [7:0] exp_q[$];
    event obs_ev;
    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;
    seewa_core #(.PROG_CYCLES(PROG_CYCLES)) uut (.sys_clk(sys_clk), .rstn(rstn),
        .select_in(select_in), .serial_clk_in(serial_clk_in), .serial_in_line(serial_in_line),
        .word_width_select(word_width_select), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .busy(busy), .prog_enabled(prog_enabled));
    seewa_host_model host (.sys_clk(sys_clk), .select_in(select_in),
        .serial_clk_in(serial_clk_in), .serial_in_line(serial_in_line));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic stop_test;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // watcher: busy, drive enable and data out during a poll
    always @(obs_ev) begin
        obs_seen = {5'h0, busy, serial_out_en, serial_out};
        check("status", obs_seen, exp_q.pop_front());
    end
    // reselect without clocks and note the status the device must show
    task automatic poll(input logic exp_busy);
        host.set_select(1'b1);
        repeat (8) @(posedge sys_clk);
        exp_q.push_back({5'h0, exp_busy, 1'b1, ~exp_busy});
        #1 -> obs_ev;
        host.set_select(1'b0);
        repeat (16) @(posedge sys_clk);
    endtask
    task automatic op(input logic [24:0] bits, input int n, input int extra, input logic eb);
        host.frame(bits, n, extra);
        poll(eb);
        if (eb) begin
            repeat (PROG_CYCLES) @(posedge sys_clk);
            poll(1'b0);
        end
        lfsr = lfsr_next(lfsr);
    endtask
    initial begin
        errors = 0;
        tests_run = 0;
        lfsr = 16'hac8b;
        rstn = 1'b0;
        word_width_select = 1'b1;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check("enable", {7'h0, prog_enabled}, 8'h0);
        op({16'h0, 3'h7, lfsr[5:0]}, 9, 0, 1'b0);
        host.frame({16'h0, 5'h13, lfsr[3:0]}, 9, 0);
        check("enable", {7'h0, prog_enabled}, 8'h1);
        r = lfsr;
        op({16'h0, 3'h7, r[5:0]}, 9, 0, 1'b1);
        check("memory", uut.mem[{1'b0, r[5:0]}], 8'hff);
        r = lfsr;
        op({16'h0, 5'h12, r[3:0]}, 9, 0, 1'b1);
        check("memory", uut.mem[{1'b1, r[5:0]}], 8'hff);
        r = lfsr;
        w = r[7:0];
        op({5'h11, r[3:0], r}, 25, 0, 1'b1);
        check("memory", uut.mem[{1'b0, r[13:8]}], w);
        check("memory", uut.mem[7'h7f], w);
        // aborted frames must leave the write-all word in place
        r = lfsr;
        op({16'h0, 3'h7, r[5:0]} >> 1, 8, 0, 1'b0);
        check("memory", uut.mem[{2'h0, r[5:1]}], w);
        r = lfsr;
        op({16'h0, 3'h7, r[5:0]}, 9, 1, 1'b0);
        check("memory", uut.mem[{1'b0, r[5:0]}], w);
        // byte organisation: seven address bits and an eight-bit data field
        word_width_select <= 1'b0;
        repeat (4) @(posedge sys_clk);
        r = lfsr;
        op({15'h0, 3'h7, r[6:0]}, 10, 0, 1'b1);
        check("memory", uut.mem[r[6:0]], 8'hff);
        r = lfsr;
        w = r[7:0];
        op({7'h0, 5'h11, r[4:0], r[7:0]}, 18, 0, 1'b1);
        check("memory", uut.mem[r[14:8]], w);
        word_width_select <= 1'b1;
        repeat (4) @(posedge sys_clk);
        host.frame({16'h0, 5'h10, lfsr[3:0]}, 9, 0);
        check("enable", {7'h0, prog_enabled}, 8'h0);
        op({16'h0, 5'h12, lfsr[3:0]}, 9, 0, 1'b0);
        check("memory", uut.mem[7'h00], w);
        stop_test();
    end
    // hang guard, well beyond the expected run of about 48 us
    initial begin
        #500000;
        errors++;
        stop_test();
    end
endmodule
bind seewa_core seewa_core_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.sys_clk(sys_clk),
    .rstn(rstn), .select_in(select_in), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .busy(busy), .prog_enabled(prog_enabled));
